// ===== hw/bsw_bay.sv
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module bsw_bay #(
  parameter int RESUME_CYCLES = bsw_pkg::RESUME_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire bsw_pkg::bsw_bus_req_t bus_req_in,
  input wire logic present_in,
  input wire logic remreq_button_in,
  output logic [31:0] rdata_out,
  output logic [4:0] bay_state_out,
  output logic wake_irq_out,
  output logic usb_resume_out
);

  // reset release
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  wire logic rst_n;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign rst_n = rst_sync2_reg;

  // request code to target state; no code maps to empty, unused codes keep the current state
  function automatic bsw_pkg::bsw_state_t req_target(
    input logic [2:0] code,
    input bsw_pkg::bsw_state_t cur
  );
    case (code)
      bsw_pkg::REQ_INSERTED: req_target = bsw_pkg::ST_INSERTED;
      bsw_pkg::REQ_ENABLED: req_target = bsw_pkg::ST_ENABLED;
      bsw_pkg::REQ_REM_REQ: req_target = bsw_pkg::ST_REM_REQ;
      bsw_pkg::REQ_REM_ALLOW: req_target = bsw_pkg::ST_REM_ALLOW;
      default: req_target = cur;
    endcase
  endfunction

  // one-hot state to readback code
  function automatic logic [2:0] state_code(input bsw_pkg::bsw_state_t st);
    case (st)
      bsw_pkg::ST_EMPTY: state_code = bsw_pkg::CODE_EMPTY;
      bsw_pkg::ST_INSERTED: state_code = bsw_pkg::CODE_INSERTED;
      bsw_pkg::ST_ENABLED: state_code = bsw_pkg::CODE_ENABLED;
      bsw_pkg::ST_REM_REQ: state_code = bsw_pkg::CODE_REM_REQ;
      bsw_pkg::ST_REM_ALLOW: state_code = bsw_pkg::CODE_REM_ALLOW;
      default: state_code = bsw_pkg::CODE_EMPTY;
    endcase
  endfunction

  // address to one-hot register select: bit 0 control, bit 1 status, bit 2 wake
  function automatic logic [2:0] reg_hit(input logic [7:0] addr);
    case (addr)
      bsw_pkg::ADDR_CTRL_EVT: reg_hit = 3'h1;
      bsw_pkg::ADDR_STATUS: reg_hit = 3'h2;
      bsw_pkg::ADDR_WAKE: reg_hit = 3'h4;
      default: reg_hit = 3'h0;
    endcase
  endfunction

  // bus decode
  wire logic [2:0] wr_hit;
  wire logic [2:0] rd_hit;
  wire logic wr_ctrl;
  wire logic wr_status;
  wire logic wr_wake;
  wire logic rd_any;
  wire logic [2:0] req_code;

  assign wr_hit = bus_req_in.wr ? reg_hit(bus_req_in.addr) : 3'h0;
  assign rd_hit = bus_req_in.rd ? reg_hit(bus_req_in.addr) : 3'h0;
  assign wr_ctrl = wr_hit[0];
  assign wr_status = wr_hit[1];
  assign wr_wake = wr_hit[2];
  assign rd_any = bus_req_in.rd;
  assign req_code = bus_req_in.wdata[bsw_pkg::CTRL_REQ_MSB:bsw_pkg::CTRL_REQ_LSB];

  // control/event register: enables only, request field is not stored
  logic chg_en_reg;
  logic remreq_en_reg;
  logic wake_ins_en_reg;
  logic wake_rem_en_reg;
  logic wake_btn_en_reg;
  logic usb_mode_reg;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chg_en_reg <= bsw_pkg::CTRL_RESET[bsw_pkg::CTRL_CHG_EN_BIT];
      remreq_en_reg <= bsw_pkg::CTRL_RESET[bsw_pkg::CTRL_REMREQ_EN_BIT];
      wake_ins_en_reg <= bsw_pkg::CTRL_RESET[bsw_pkg::CTRL_WAKE_INS_BIT];
      wake_rem_en_reg <= bsw_pkg::CTRL_RESET[bsw_pkg::CTRL_WAKE_REM_BIT];
      wake_btn_en_reg <= bsw_pkg::CTRL_RESET[bsw_pkg::CTRL_WAKE_BTN_BIT];
    end else if (wr_ctrl) begin
      chg_en_reg <= bus_req_in.wdata[bsw_pkg::CTRL_CHG_EN_BIT];
      remreq_en_reg <= bus_req_in.wdata[bsw_pkg::CTRL_REMREQ_EN_BIT];
      wake_ins_en_reg <= bus_req_in.wdata[bsw_pkg::CTRL_WAKE_INS_BIT];
      wake_rem_en_reg <= bus_req_in.wdata[bsw_pkg::CTRL_WAKE_REM_BIT];
      wake_btn_en_reg <= bus_req_in.wdata[bsw_pkg::CTRL_WAKE_BTN_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      usb_mode_reg <= 1'b0;
    end else if (wr_wake) begin
      usb_mode_reg <= bus_req_in.wdata[bsw_pkg::WAKE_USB_MODE_BIT];
    end
  end

  // physical events
  logic present_d_reg;
  logic button_d_reg;
  wire logic insert_evt;
  wire logic remove_evt;
  wire logic button_evt;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      present_d_reg <= 1'b0;
      button_d_reg <= 1'b0;
    end else begin
      present_d_reg <= present_in;
      button_d_reg <= remreq_button_in;
    end
  end

  assign insert_evt = present_in && !present_d_reg;
  assign remove_evt = !present_in && present_d_reg;
  assign button_evt = remreq_button_in && !button_d_reg;

  // sticky event flags, write one to clear, a new event wins
  // index 0 insert, 1 remove, 2 button, in status bit order
  wire logic [2:0] evt_vec;
  wire logic [2:0] wake_en_vec;
  wire logic [2:0] flag_vec;
  wire logic [2:0] wake_src_vec;

  assign evt_vec = {button_evt, remove_evt, insert_evt};
  assign wake_en_vec = {wake_btn_en_reg, wake_rem_en_reg, wake_ins_en_reg};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_evt_flag
      logic flag_reg;
      logic flag_next;
      wire logic clr;

      assign clr = wr_status && bus_req_in.wdata[bsw_pkg::STS_INS_FLAG_BIT + i];

      always_comb begin
        flag_next = evt_vec[i] || (flag_reg && !clr);
      end

      always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
          flag_reg <= 1'b0;
        end else begin
          flag_reg <= flag_next;
        end
      end

      assign flag_vec[i] = flag_reg;
      assign wake_src_vec[i] = flag_reg && wake_en_vec[i];
    end
  endgenerate

  // bay state machine
  bsw_pkg::bsw_state_t state_reg;
  bsw_pkg::bsw_state_t state_next;
  bsw_pkg::bsw_state_t sw_target;
  wire logic sw_req;
  wire logic hw_remreq;

  assign sw_req = wr_ctrl && present_in;
  assign hw_remreq = button_evt && remreq_en_reg;

  always_comb begin
    sw_target = req_target(req_code, state_reg);
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bsw_pkg::ST_EMPTY: begin
        if (!present_in) begin
          state_next = bsw_pkg::ST_EMPTY;
        end else if (insert_evt && chg_en_reg) begin
          state_next = bsw_pkg::ST_INSERTED;
        end else if (sw_req) begin
          state_next = sw_target;
        end
      end
      bsw_pkg::ST_INSERTED: begin
        if (!present_in) begin
          state_next = bsw_pkg::ST_EMPTY;
        end else if (sw_req) begin
          state_next = sw_target;
        end else if (hw_remreq) begin
          state_next = bsw_pkg::ST_REM_REQ;
        end
      end
      bsw_pkg::ST_ENABLED: begin
        if (!present_in) begin
          state_next = bsw_pkg::ST_EMPTY;
        end else if (sw_req) begin
          state_next = sw_target;
        end else if (hw_remreq) begin
          state_next = bsw_pkg::ST_REM_REQ;
        end
      end
      bsw_pkg::ST_REM_REQ: begin
        if (!present_in) begin
          state_next = bsw_pkg::ST_EMPTY;
        end else if (sw_req) begin
          state_next = sw_target;
        end
      end
      bsw_pkg::ST_REM_ALLOW: begin
        if (!present_in) begin
          state_next = bsw_pkg::ST_EMPTY;
        end else if (sw_req) begin
          state_next = sw_target;
        end
      end
      default: begin
        state_next = bsw_pkg::ST_EMPTY;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= bsw_pkg::ST_EMPTY;
    end else begin
      state_reg <= state_next;
    end
  end

  // wake generation
  wire logic wake_pending;
  logic wake_pending_d_reg;
  logic wake_irq_reg;
  wire logic resume_start;

  assign wake_pending = |wake_src_vec;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wake_pending_d_reg <= 1'b0;
      wake_irq_reg <= 1'b0;
    end else begin
      wake_pending_d_reg <= wake_pending;
      // held off while a resume still runs, so a mode change never overlaps the two
      wake_irq_reg <= wake_pending && !usb_mode_reg && !usb_resume_out;
    end
  end

  assign resume_start = wake_pending && !wake_pending_d_reg && usb_mode_reg;

  bsw_resume #(
    .RESUME_CYCLES(RESUME_CYCLES)
  ) u_resume (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(resume_start),
    .resume_out(usb_resume_out)
  );

  // read path
  wire logic [31:0] ctrl_word;
  wire logic [31:0] status_word;
  wire logic [31:0] wake_word;
  logic [31:0] rd_sel;
  logic [31:0] rdata_reg;

  assign ctrl_word = {24'h000000, wake_btn_en_reg, 3'h0, wake_rem_en_reg,
                      wake_ins_en_reg, remreq_en_reg, chg_en_reg};
  assign status_word = {25'h0, flag_vec, state_code(state_reg), present_in};
  assign wake_word = {30'h0, wake_pending, usb_mode_reg};

  always_comb begin
    case (rd_hit)
      3'h1: rd_sel = ctrl_word;
      3'h2: rd_sel = status_word;
      3'h4: rd_sel = wake_word;
      default: rd_sel = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_any) begin
      rdata_reg <= rd_sel;
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign rdata_out = rdata_reg;
  assign bay_state_out = state_reg;
  assign wake_irq_out = wake_irq_reg;
endmodule

// ===== hw/bsw_pkg.sv
package bsw_pkg;
  localparam logic [7:0] ADDR_CTRL_EVT = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_WAKE = 8'h08;

  // control/event register fields
  localparam int CTRL_CHG_EN_BIT = 0;
  localparam int CTRL_REMREQ_EN_BIT = 1;
  localparam int CTRL_WAKE_INS_BIT = 2;
  localparam int CTRL_WAKE_REM_BIT = 3;
  localparam int CTRL_REQ_LSB = 4;
  localparam int CTRL_REQ_MSB = 6;
  localparam int CTRL_WAKE_BTN_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status register fields
  localparam int STS_PRESENT_BIT = 0;
  localparam int STS_STATE_LSB = 1;
  localparam int STS_STATE_MSB = 3;
  localparam int STS_INS_FLAG_BIT = 4;
  localparam int STS_REM_FLAG_BIT = 5;
  localparam int STS_BTN_FLAG_BIT = 6;

  // wake register fields
  localparam int WAKE_USB_MODE_BIT = 0;
  localparam int WAKE_PENDING_BIT = 1;

  // request codes
  localparam logic [2:0] REQ_INSERTED = 3'h1;
  localparam logic [2:0] REQ_ENABLED = 3'h2;
  localparam logic [2:0] REQ_REM_REQ = 3'h3;
  localparam logic [2:0] REQ_REM_ALLOW = 3'h4;

  // state readback codes
  localparam logic [2:0] CODE_EMPTY = 3'h0;
  localparam logic [2:0] CODE_INSERTED = 3'h1;
  localparam logic [2:0] CODE_ENABLED = 3'h2;
  localparam logic [2:0] CODE_REM_REQ = 3'h3;
  localparam logic [2:0] CODE_REM_ALLOW = 3'h4;

  // timing
  localparam int CLK_MHZ = 50;
  localparam int RESUME_TIME_US = 1000;
  localparam int RESUME_CYCLES = RESUME_TIME_US * CLK_MHZ;

  typedef enum logic [4:0] {
    ST_EMPTY = 5'h01,
    ST_INSERTED = 5'h02,
    ST_ENABLED = 5'h04,
    ST_REM_REQ = 5'h08,
    ST_REM_ALLOW = 5'h10
  } bsw_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bsw_bus_req_t;
endpackage

// ===== hw/bsw_resume.sv
`timescale 1ns/1ps
module bsw_resume #(
  parameter int RESUME_CYCLES = bsw_pkg::RESUME_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  output logic resume_out
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic resume_reg;
  logic resume_next;
  wire logic done;

  assign done = (count_reg == 32'h00000001);

  always_comb begin
    count_next = count_reg;
    resume_next = resume_reg;
    if (!resume_reg && start_in) begin
      count_next = 32'(RESUME_CYCLES);
      resume_next = 1'b1;
    end else if (resume_reg) begin
      count_next = count_reg - 32'h00000001;
      if (done) begin
        resume_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= 32'h00000000;
      resume_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      resume_reg <= resume_next;
    end
  end

  assign resume_out = resume_reg;
endmodule

// ===== verif/bsw_bay_assertions.sv
`timescale 1ns/1ps
module bsw_bay_assertions #(
  parameter int RESUME_CYCLES = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire bsw_pkg::bsw_bus_req_t bus_req_in,
  input wire logic present_in,
  input wire logic remreq_button_in,
  input wire logic [31:0] rdata_out,
  input wire logic [4:0] bay_state_out,
  input wire logic wake_irq_out,
  input wire logic usb_resume_out
);
  wire logic ctl_wr = bus_req_in.wr && (bus_req_in.addr == bsw_pkg::ADDR_CTRL_EVT);
  wire logic [2:0] code = bus_req_in.wdata[bsw_pkg::CTRL_REQ_MSB:bsw_pkg::CTRL_REQ_LSB];
  wire logic code_ok = (code != 3'h0) && (code <= 3'h4);
  logic [31:0] res_cnt;
  // length of the current resume pulse so far
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      res_cnt <= 32'h0;
    end else begin
      res_cnt <= usb_resume_out ? res_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // device held, no button edge nearby
  sequence s_quiet;
    present_in && $past(present_in) && !remreq_button_in && !$past(remreq_button_in);
  endsequence
  sequence s_req;
    ctl_wr ##0 s_quiet;
  endsequence
  a_req_moves: assert property (s_req ##0 code_ok |=>
    bay_state_out == (5'h01 << $past(code))) else $error("request code not obeyed");
  a_bad_code_hold: assert property (s_req ##0 !code_ok |=> $stable(bay_state_out))
    else $error("unused code moved the state");
  a_empty_ignore: assert property (ctl_wr && !present_in |=> bay_state_out == 5'h01)
    else $error("request taken with bay empty");
  a_never_empty: assert property (s_req ##0 (bay_state_out != 5'h01) |=>
    bay_state_out != 5'h01) else $error("software produced empty state");
  a_static_field: assert property (!ctl_wr ##0 s_quiet |=> $stable(bay_state_out))
    else $error("state moved without a write");
  a_state_onehot: assert property ($onehot(bay_state_out))
    else $error("state not one-hot");
  a_wake_exclusive: assert property (!(wake_irq_out && usb_resume_out))
    else $error("irq and resume together");
  a_resume_len: assert property ($fell(usb_resume_out) |-> res_cnt == RESUME_CYCLES)
    else $error("resume pulse length wrong");
  a_resume_cap: assert property (usb_resume_out |-> res_cnt < RESUME_CYCLES)
    else $error("resume pulse too long");
  a_rdata_idle: assert property (!bus_req_in.rd |=> rdata_out == 32'h0)
    else $error("read data outside read slot");
  a_field_reads0: assert property (bus_req_in.rd &&
    bus_req_in.addr == bsw_pkg::ADDR_CTRL_EVT |=> rdata_out[6:4] == 3'h0)
    else $error("request field reads nonzero");
endmodule

// ===== verif/bsw_bay_tb.sv
`timescale 1ns/1ps
module bsw_bay_tb;
  localparam int RES_N = 8;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  bsw_pkg::bsw_bus_req_t bus_req_in = '0;
  logic present_in = 1'b0;
  logic remreq_button_in = 1'b0;
  logic [31:0] rdata_out;
  logic [4:0] bay_state_out;
  logic wake_irq_out;
  logic usb_resume_out;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  logic [31:0] rd_val;
  logic [7:0] en = 8'h00;
  bsw_bay #(.RESUME_CYCLES(RES_N)) u_bsw_bay (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .bus_req_in(bus_req_in),
    .present_in(present_in),
    .remreq_button_in(remreq_button_in),
    .rdata_out(rdata_out),
    .bay_state_out(bay_state_out),
    .wake_irq_out(wake_irq_out),
    .usb_resume_out(usb_resume_out)
  );
  always #10 clk_in = ~clk_in;
  task automatic final_report();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_req_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    bus_req_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_req_in.rd <= 1'b0;
    #1 rd_val = rdata_out;
  endtask
  // request a code, then check state port and status readback
  task automatic step(input logic [2:0] c, input logic [2:0] s);
    wr(bsw_pkg::ADDR_CTRL_EVT, {24'h0, en} | {25'h0, c, 4'h0});
    #1 chk("state", {27'h0, 5'h01 << s}, {27'h0, bay_state_out});
    rd(bsw_pkg::ADDR_STATUS);
    chk("status", {28'h0, s, 1'b1}, {28'h0, rd_val[3:0]});
  endtask
  task automatic wait_out(input bit usb, input logic exp);
    logic v;
    v = 1'b0;
    #1;
    for (int i = 0; i < 20; i++) begin
      v = usb ? usb_resume_out : wake_irq_out;
      if (v === exp) break;
      @(posedge clk_in);
      #1;
    end
    chk(usb ? "resume" : "irq", {31'h0, exp}, {31'h0, v});
    if (v !== exp) final_report();
  endtask
  task automatic set_pres(input logic p);
    @(posedge clk_in);
    present_in <= p;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 chk("reset state", 32'h1, {27'h0, bay_state_out});
    chk("reset irq", 32'h0, {31'h0, wake_irq_out});
    rd(bsw_pkg::ADDR_CTRL_EVT);
    chk("ctrl reset", {24'h0, bsw_pkg::CTRL_RESET}, rd_val);
    wr(bsw_pkg::ADDR_CTRL_EVT, 32'h10);
    #1 chk("empty bay", 32'h1, {27'h0, bay_state_out});
    set_pres(1'b1);
    step(3'h1, 3'h1);
    step(3'h2, 3'h2);
    step(3'h3, 3'h3);
    step(3'h2, 3'h2);
    step(3'h3, 3'h3);
    step(3'h4, 3'h4);
    step(3'h1, 3'h1);
    step(3'h3, 3'h3);
    step(3'h4, 3'h4);
    step(3'h1, 3'h1);
    step(3'h4, 3'h4);
    step(3'h3, 3'h3);
    step(3'h1, 3'h1);
    step(3'h2, 3'h2);
    step(3'h1, 3'h1);
    for (int c = 0; c < 8; c++) begin
      if (c == 0 || c > 4) step(c[2:0], 3'h1);
    end
    step(3'h4, 3'h4);
    step(3'h2, 3'h2);
    repeat (5) @(posedge clk_in);
    #1 chk("held state", 32'h4, {27'h0, bay_state_out});
    rd(bsw_pkg::ADDR_CTRL_EVT);
    chk("req field", 32'h0, {29'h0, rd_val[6:4]});
    wr(8'h0C, 32'h30);
    wr(bsw_pkg::ADDR_STATUS, 32'h70);
    #1 chk("other write", 32'h4, {27'h0, bay_state_out});
    rd(8'h0C);
    chk("unmapped", 32'h0, rd_val);
    set_pres(1'b0);
    set_pres(1'b1);
    step(3'h2, 3'h2);
    en = 8'h04;
    wr(bsw_pkg::ADDR_CTRL_EVT, {24'h0, en});
    wr(bsw_pkg::ADDR_STATUS, 32'h70);
    set_pres(1'b0);
    chk("masked wake", 32'h0, {31'h0, wake_irq_out});
    wr(bsw_pkg::ADDR_STATUS, 32'h70);
    set_pres(1'b1);
    wait_out(1'b0, 1'b1);
    wr(bsw_pkg::ADDR_STATUS, 32'h70);
    wait_out(1'b0, 1'b0);
    step(3'h2, 3'h2);
    en = 8'h82;
    wr(bsw_pkg::ADDR_CTRL_EVT, {24'h0, en});
    rd(bsw_pkg::ADDR_CTRL_EVT);
    chk("ctrl enables", 32'h82, rd_val);
    @(posedge clk_in);
    remreq_button_in <= 1'b1;
    wait_out(1'b0, 1'b1);
    rd(bsw_pkg::ADDR_STATUS);
    chk("event flags", 32'h4, {29'h0, rd_val[6:4]});
    @(posedge clk_in);
    remreq_button_in <= 1'b0;
    wr(bsw_pkg::ADDR_STATUS, 32'h70);
    wait_out(1'b0, 1'b0);
    en = 8'h08;
    wr(bsw_pkg::ADDR_CTRL_EVT, {24'h0, en});
    wr(bsw_pkg::ADDR_WAKE, 32'h1);
    @(posedge clk_in);
    present_in <= 1'b0;
    wait_out(1'b1, 1'b1);
    n = 0;
    while (usb_resume_out === 1'b1 && n < 50) begin
      n++;
      @(posedge clk_in);
      #1;
    end
    chk("resume len", RES_N, n);
    chk("irq in usb", 32'h0, {31'h0, wake_irq_out});
    rd(bsw_pkg::ADDR_WAKE);
    chk("wake reg", 32'h3, rd_val);
    final_report();
  end
endmodule
bind bsw_bay bsw_bay_assertions #(.RESUME_CYCLES(RESUME_CYCLES)) u_bsw_bay_assertions (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .bus_req_in(bus_req_in),
  .present_in(present_in),
  .remreq_button_in(remreq_button_in),
  .rdata_out(rdata_out),
  .bay_state_out(bay_state_out),
  .wake_irq_out(wake_irq_out),
  .usb_resume_out(usb_resume_out)
);
